/* File: rxe_pkg.sv */
// shared constants and types of the receive error-syndrome unit
package rxe_pkg;
    // ==========================================
    // structure
    localparam int NUM_CHAN = 4;
    localparam int SYND_W = 4;
    localparam int MSG_W = 16;
    localparam int FS_W = 4;
    // input buffer depth, no less than the minimum asked of it
    localparam int FIFO_DEPTH = 4;
    localparam int PTR_W = 2;
    localparam int CNT_W = 3;
    // entry layout: {overload, syndrome, message}
    localparam int ENT_W = MSG_W + SYND_W + 1;
    localparam int ENT_MSG_LSB = 0;
    localparam int ENT_SYN_LSB = MSG_W;
    localparam int ENT_OVL_BIT = MSG_W + SYND_W;
    // ==========================================
    // frame sync completes on the ready pulse that arrives after this many, the third
    localparam logic [1:0] FS_LAST_PULSE = 2'h2;
    // ==========================================
    // minor-mode commands; node reset is the first
    typedef enum logic [3:0] {
        RXE_CMD_RESET = 4'h0,
        RXE_CMD_ASYNC_MON = 4'h1,
        RXE_CMD_SYNC_RX = 4'h2,
        RXE_CMD_FIXED_DLY = 4'h3,
        RXE_CMD_SYNC_CAPTURE = 4'h4,
        RXE_CMD_DIAGNOSIS = 4'h5,
        RXE_CMD_SCHED_UPDATE = 4'h6,
        RXE_CMD_PE_COMM = 4'h7,
        RXE_CMD_SYNC_KEEP = 4'h8
    } rxe_cmd_type;
    // ==========================================
    // control states
    typedef enum logic [2:0] {
        RXE_ST_IDLE = 3'b001,
        RXE_ST_BUSY = 3'b010,
        RXE_ST_WIN = 3'b100
    } rxe_state_type;
endpackage

/* File: rxe_chan_fifo.sv */
// per-channel input buffer with occupancy count
`timescale 1ns/1ps
module rxe_chan_fifo (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic push,
    input wire logic pop,
    input wire logic [rxe_pkg::ENT_W-1:0] wdata,
    output logic [rxe_pkg::ENT_W-1:0] rdata,
    output logic [rxe_pkg::CNT_W-1:0] count,
    output logic full,
    output logic empty
);
    import rxe_pkg::*;
    // ==========================================
    // storage
    logic [ENT_W-1:0] mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [CNT_W-1:0] next_count;
    logic do_push;
    logic do_pop;

    assign full = (count == CNT_W'(FIFO_DEPTH));
    assign empty = (count == '0);
    assign rdata = mem[rd_ptr];
    assign do_pop = pop && !empty;
    assign do_push = push && (!full || do_pop);

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (clear) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end else begin
            if (do_push)
                next_wr_ptr = wr_ptr + PTR_W'(1);
            if (do_pop)
                next_rd_ptr = rd_ptr + PTR_W'(1);
            next_count = count + CNT_W'(do_push) - CNT_W'(do_pop);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // stored entries are never overwritten
    always_ff @(posedge clk) begin
        if (do_push && !clear)
            mem[wr_ptr] <= wdata;
    end

    AST_FULL_HOLDS: assert property (@(posedge clk) disable iff (rst)
        full && push && !pop && !clear |=> count == $past(count))
        else $error("full buffer took a message");
endmodule

/* File: rxe_fsync.sv */
// frame sync syndrome capture on process completion
`timescale 1ns/1ps
module rxe_fsync (
    input wire logic clk,
    input wire logic rst,
    input wire logic sreset,
    input wire logic capture_mode,
    input wire logic ready_pulse,
    input wire logic [rxe_pkg::FS_W-1:0] synd_in,
    output logic [rxe_pkg::FS_W-1:0] synd_out
);
    import rxe_pkg::*;
    // ==========================================
    // ready pulse counter
    logic [1:0] pulses;
    logic [1:0] next_pulses;
    logic [FS_W-1:0] next_synd_out;
    logic done;

    assign done = capture_mode && ready_pulse && pulses == FS_LAST_PULSE;

    always_comb begin
        next_pulses = pulses;
        next_synd_out = synd_out;
        if (sreset || !capture_mode) begin
            next_pulses = '0;
        end else if (done) begin
            next_pulses = '0;
            next_synd_out = synd_in;
        end else if (ready_pulse) begin
            next_pulses = pulses + 2'h1;
        end
        if (sreset)
            next_synd_out = '0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulses <= '0;
            synd_out <= '0;
        end else begin
            pulses <= next_pulses;
            synd_out <= next_synd_out;
        end
    end

    sequence seq_third_pulse;
        capture_mode && ready_pulse && pulses == FS_LAST_PULSE && !sreset;
    endsequence

    AST_FS_REPORT: assert property (@(posedge clk) disable iff (rst)
        seq_third_pulse |=> synd_out == $past(synd_in))
        else $error("frame sync syndrome not reported");
endmodule

/* File: rxe_unit.sv */
// receive-side error-syndrome unit, top level
`timescale 1ns/1ps
// Contract
// - each receiver strobe means fresh message and syndrome; unit takes them
// - channel strobe and immediate syndromes appear one tick after transaction
// - immediate syndrome timing ignores window state
// - async monitoring presents message and aligned syndrome one tick later
// - other modes output aligned syndrome with its buffered message
// - aligned syndrome never asserted for receptions outside windows
// - aligned syndrome valid with window and strobe or ready pulse
// - overrun extra message never reaches aligned outputs
// - overload flagged when load exceeds maximum, tied to triggering message
// - no overload during async monitoring windows
// - immediate overload one tick after trigger in buffered modes
// - aligned overload rises with offending message on output
// - single-message window: overrun flag with expected output, not overload
// - each buffer holds at least the minimum depth
// - no overwrite; full drops arrivals unless a read coincides
// - dropped messages still give strobe and immediate flags only
// - frame sync syndrome reported on third ready pulse of capture mode
// - node reset honoured anytime, back to default
// - each command executed independently of order
// - every window starts with empty buffers
// - default state within two ticks of node reset
module rxe_unit (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic NODE_RESET,
    input wire logic CMD_VALID,
    input wire logic [3:0] CMD_CODE,
    input wire logic CMD_DONE,
    input wire logic WINDOW_OPEN,
    input wire logic OUT_TAKE,
    input wire logic OUT_LAST,
    input wire logic [rxe_pkg::CNT_W-1:0] MAX_LOAD,
    input wire logic [rxe_pkg::NUM_CHAN-1:0] LINK_RX_STROBE,
    input wire logic [rxe_pkg::NUM_CHAN*rxe_pkg::MSG_W-1:0] LINK_RX_MESSAGE,
    input wire logic [rxe_pkg::NUM_CHAN*rxe_pkg::SYND_W-1:0] LINK_RX_SYND,
    input wire logic [rxe_pkg::FS_W-1:0] FRAME_SYNC_ERRORS,
    output logic IDLE,
    output logic WINDOW_ACTIVE,
    output logic OUTPUT_READY_PULSE,
    output logic [rxe_pkg::NUM_CHAN-1:0] CHAN_OUT_STROBE,
    output logic [rxe_pkg::NUM_CHAN*rxe_pkg::SYND_W-1:0]
        IMMEDIATE_LINK_SYNDROME,
    output logic [rxe_pkg::NUM_CHAN-1:0] IMMEDIATE_OVERLOAD_FLAG,
    output logic [rxe_pkg::NUM_CHAN*rxe_pkg::MSG_W-1:0] ALIGNED_MESSAGE_OUT,
    output logic [rxe_pkg::NUM_CHAN*rxe_pkg::SYND_W-1:0]
        ALIGNED_LINK_SYNDROME,
    output logic [rxe_pkg::NUM_CHAN-1:0] ALIGNED_OVERLOAD_FLAG,
    output logic [rxe_pkg::NUM_CHAN-1:0] INPUT_OVERRUN_FLAG,
    output logic [rxe_pkg::FS_W-1:0] FRAME_SYNC_SYNDROME
);
    import rxe_pkg::*;

    // ==========================================
    // command and window control
    rxe_state_type state;
    rxe_state_type next_state;
    rxe_cmd_type mode;
    rxe_cmd_type next_mode;
    logic next_ready;
    logic sreset;
    logic async_mode;
    logic win;
    logic take;

    // node reset or reset command wins over all else
    assign sreset = NODE_RESET ||
        (CMD_VALID && rxe_cmd_type'(CMD_CODE) == RXE_CMD_RESET);
    assign win = (state == RXE_ST_WIN);
    assign async_mode = (mode == RXE_CMD_ASYNC_MON);
    assign take = OUT_TAKE && win && !async_mode;
    assign IDLE = (state == RXE_ST_IDLE);
    assign WINDOW_ACTIVE = win;

    always_comb begin
        next_state = state;
        next_mode = mode;
        next_ready = take;
        // each command stands alone, no history kept
        unique case (state)
            RXE_ST_IDLE: begin
                if (CMD_VALID) begin
                    next_mode = rxe_cmd_type'(CMD_CODE);
                    next_state = RXE_ST_BUSY;
                end
            end
            RXE_ST_BUSY: begin
                if (CMD_DONE)
                    next_state = RXE_ST_IDLE;
                else if (WINDOW_OPEN)
                    next_state = RXE_ST_WIN;
            end
            RXE_ST_WIN: begin
                if (CMD_DONE)
                    next_state = RXE_ST_IDLE;
                else if (!WINDOW_OPEN)
                    next_state = RXE_ST_BUSY;
            end
            default: next_state = RXE_ST_IDLE;
        endcase
        // default reached one tick after reset seen
        if (sreset) begin
            next_state = RXE_ST_IDLE;
            next_mode = RXE_CMD_RESET;
            next_ready = 1'b0;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= RXE_ST_IDLE;
            mode <= RXE_CMD_RESET;
            OUTPUT_READY_PULSE <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            OUTPUT_READY_PULSE <= next_ready;
        end
    end

    // ==========================================
    // per-channel paths
    genvar i;
    generate
        for (i = 0; i < NUM_CHAN; i++) begin : g_chan
            logic strobe;
            logic [MSG_W-1:0] msg;
            logic [SYND_W-1:0] synd;
            logic [ENT_W-1:0] head;
            logic [CNT_W-1:0] count;
            logic full;
            logic empty;
            logic accept;
            logic flush;
            logic popped;
            logic stored;
            logic [CNT_W:0] load;
            logic [CNT_W:0] left;
            logic ovl;
            logic next_strobe;
            logic [SYND_W-1:0] next_imm_synd;
            logic next_imm_ovl;
            logic [MSG_W-1:0] next_msg;
            logic [SYND_W-1:0] next_lnk;
            logic next_ovl;
            logic next_ovr;

            // every strobe is a transaction, error-only or not
            assign strobe = LINK_RX_STROBE[i];
            assign msg = LINK_RX_MESSAGE[i*MSG_W +: MSG_W];
            assign synd = LINK_RX_SYND[i*SYND_W +: SYND_W];
            // buffered modes load only inside windows
            assign accept = strobe && win && !async_mode;
            // buffers emptied as a window opens
            assign flush = sreset || (WINDOW_OPEN && !win);
            assign popped = take && !empty;
            assign stored = accept && (!full || popped);
            assign load = {1'b0, count} + (CNT_W+1)'(1)
                - (CNT_W+1)'(popped);
            assign left = {1'b0, count} + (CNT_W+1)'(stored)
                - (CNT_W+1)'(popped);
            // overload tied to the triggering message
            assign ovl = accept && (load > {1'b0, MAX_LOAD});

            rxe_chan_fifo u_fifo (
                .clk(MCLK),
                .rst(RST),
                .clear(flush),
                .push(accept),
                .pop(take),
                .wdata({ovl, synd, msg}),
                .rdata(head),
                .count(count),
                .full(full),
                .empty(empty)
            );

            always_comb begin
                next_strobe = strobe;
                next_imm_synd = strobe ? synd
                    : IMMEDIATE_LINK_SYNDROME[i*SYND_W +: SYND_W];
                next_imm_ovl = ovl;
                next_msg = ALIGNED_MESSAGE_OUT[i*MSG_W +: MSG_W];
                next_lnk = '0;
                next_ovl = 1'b0;
                next_ovr = 1'b0;
                if (async_mode && strobe) begin
                    // message and syndrome one tick after reception
                    next_msg = msg;
                    next_lnk = win ? synd : '0;
                end else if (take) begin
                    // extra messages stay behind, flushed later
                    if (!empty) begin
                        next_msg = head[ENT_MSG_LSB +: MSG_W];
                        next_lnk = head[ENT_SYN_LSB +: SYND_W];
                        next_ovl = head[ENT_OVL_BIT];
                    end
                    // leftovers at last output are overrun
                    next_ovr = OUT_LAST && (left != '0);
                end
                if (sreset) begin
                    next_strobe = 1'b0;
                    next_imm_synd = '0;
                    next_imm_ovl = 1'b0;
                    next_msg = '0;
                    next_lnk = '0;
                    next_ovl = 1'b0;
                    next_ovr = 1'b0;
                end
            end

            always_ff @(posedge MCLK or posedge RST) begin
                if (RST) begin
                    CHAN_OUT_STROBE[i] <= 1'b0;
                    IMMEDIATE_LINK_SYNDROME[i*SYND_W +: SYND_W] <= '0;
                    IMMEDIATE_OVERLOAD_FLAG[i] <= 1'b0;
                    ALIGNED_MESSAGE_OUT[i*MSG_W +: MSG_W] <= '0;
                    ALIGNED_LINK_SYNDROME[i*SYND_W +: SYND_W] <= '0;
                    ALIGNED_OVERLOAD_FLAG[i] <= 1'b0;
                    INPUT_OVERRUN_FLAG[i] <= 1'b0;
                end else begin
                    CHAN_OUT_STROBE[i] <= next_strobe;
                    IMMEDIATE_LINK_SYNDROME[i*SYND_W +: SYND_W]
                        <= next_imm_synd;
                    IMMEDIATE_OVERLOAD_FLAG[i] <= next_imm_ovl;
                    ALIGNED_MESSAGE_OUT[i*MSG_W +: MSG_W] <= next_msg;
                    ALIGNED_LINK_SYNDROME[i*SYND_W +: SYND_W] <= next_lnk;
                    ALIGNED_OVERLOAD_FLAG[i] <= next_ovl;
                    INPUT_OVERRUN_FLAG[i] <= next_ovr;
                end
            end
        end
    endgenerate

    // ==========================================
    // frame sync syndromes
    rxe_fsync u_fsync (
        .clk(MCLK),
        .rst(RST),
        .sreset(sreset),
        .capture_mode(mode == RXE_CMD_SYNC_CAPTURE),
        .ready_pulse(OUTPUT_READY_PULSE),
        .synd_in(FRAME_SYNC_ERRORS),
        .synd_out(FRAME_SYNC_SYNDROME)
    );

    // ==========================================
    // checks, channel 0 stands for all
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence seq_rx0;
        LINK_RX_STROBE[0] && !sreset;
    endsequence

    sequence seq_async_rx0;
        seq_rx0 ##0 async_mode;
    endsequence

    sequence seq_take_head0;
        take && !sreset && !g_chan[0].empty;
    endsequence

    AST_STROBE_ECHO: assert property (
        seq_rx0 |=> CHAN_OUT_STROBE[0] &&
            IMMEDIATE_LINK_SYNDROME[SYND_W-1:0]
                == $past(LINK_RX_SYND[SYND_W-1:0]))
        else $error("channel strobe or syndrome not one tick later");

    AST_ASYNC_MSG: assert property (
        seq_async_rx0 |=> ALIGNED_MESSAGE_OUT[MSG_W-1:0]
            == $past(LINK_RX_MESSAGE[MSG_W-1:0]))
        else $error("async message not presented one tick later");

    AST_NO_WIN_SYND: assert property (
        seq_async_rx0 ##0 !win |=> ALIGNED_LINK_SYNDROME[SYND_W-1:0] == '0)
        else $error("aligned syndrome set outside window");

    AST_ALIGNED_PAIR: assert property (
        seq_take_head0 |=> OUTPUT_READY_PULSE &&
            ALIGNED_LINK_SYNDROME[SYND_W-1:0]
                == $past(g_chan[0].head[ENT_SYN_LSB +: SYND_W]) &&
            ALIGNED_OVERLOAD_FLAG[0] == $past(g_chan[0].head[ENT_OVL_BIT]))
        else $error("aligned syndrome not with its message");

    AST_NO_ASYNC_OVL: assert property (
        async_mode && !sreset |=> !IMMEDIATE_OVERLOAD_FLAG[0])
        else $error("overload flagged in async monitoring");

    AST_IMM_OVL: assert property (
        seq_rx0 ##0 win ##0 !async_mode ##0
            (g_chan[0].load > {1'b0, MAX_LOAD}) |=> IMMEDIATE_OVERLOAD_FLAG[0])
        else $error("immediate overload missing");

    AST_WIN_EMPTY: assert property (
        $rose(win) |-> g_chan[0].count == '0)
        else $error("window opened with stored messages");

    AST_NODE_RST: assert property (
        NODE_RESET |=> IDLE && !WINDOW_ACTIVE && CHAN_OUT_STROBE == '0 &&
            !OUTPUT_READY_PULSE)
        else $error("node reset left unit active");

    AST_OVERRUN: assert property (
        take && OUT_LAST && !sreset && g_chan[0].left != '0
            |=> INPUT_OVERRUN_FLAG[0] && OUTPUT_READY_PULSE)
        else $error("overrun not flagged at last output");
endmodule

/* File: rxe_link_model.sv */
// link receiver model: strobe, message and syndromes per channel
`timescale 1ns/1ps
module rxe_link_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [rxe_pkg::NUM_CHAN-1:0] send,
    input wire logic [rxe_pkg::MSG_W-1:0] msg,
    input wire logic [rxe_pkg::SYND_W-1:0] synd,
    output logic [rxe_pkg::NUM_CHAN-1:0] strobe,
    output logic [rxe_pkg::NUM_CHAN*rxe_pkg::MSG_W-1:0] message,
    output logic [rxe_pkg::NUM_CHAN*rxe_pkg::SYND_W-1:0] synd_out
);
    import rxe_pkg::*;
    // ==========================================
    // receiver outputs
    // strobe per transaction
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe <= '0;
            message <= '0;
            synd_out <= '0;
        end else begin
            strobe <= send;
            for (int i = 0; i < NUM_CHAN; i++) begin
                // stale data inverted, so no one leans on a held value
                message[MSG_W*i+:MSG_W] <= send[i] ? msg :
                    ~message[MSG_W*i+:MSG_W];
                synd_out[SYND_W*i+:SYND_W] <= send[i] ? synd :
                    ~synd_out[SYND_W*i+:SYND_W];
            end
        end
    end
endmodule

/* File: rxe_unit_bench.sv */
// self-checking bench of the receive error-syndrome unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
    checks++; \
    if ((gt) !== (ex)) begin \
        mismatches++; \
        $display("ERROR %s exp %h got %h", nm, ex, gt); \
    end \
end
module rxe_unit_bench;
    import rxe_pkg::*;
    typedef struct packed {
        logic [1:0] ch;
        logic [15:0] m;
        logic [3:0] s;
        logic [3:0] es;
    } rxe_row_type;
    // ==========================================
    // stimulus and observed signals
    logic mclk = 0;
    logic rst = 1;
    logic node_reset = 0;
    logic cmd_valid = 0;
    logic cmd_done = 0;
    logic window_open = 0;
    logic out_take = 0;
    logic out_last = 0;
    logic [3:0] cmd_code = 4'h0;
    logic [2:0] max_load = 3'h0;
    logic [3:0] fs_err = 4'h0;
    logic [3:0] snd = 4'h0;
    logic [15:0] msg = 16'h0;
    logic [3:0] syn = 4'h0;
    logic idle, win_active, ready;
    logic [3:0] chan_strobe, imm_ovl, al_ovl, overrun, fs_out, lk_strobe;
    logic [15:0] imm_syn, al_syn, lk_syn;
    logic [63:0] al_msg, lk_msg;
    int checks = 0;
    int mismatches = 0;
    int cycles = 0;
    int seq[4] = '{2, 3, 4, 6};
    rxe_row_type rows[4] = '{'{2'h0, 16'ha5a5, 4'h0, 4'h0},
        '{2'h1, 16'h5a5a, 4'h3, 4'h3}, '{2'h2, 16'h0001, 4'hf, 4'hf},
        '{2'h3, 16'hffff, 4'h8, 4'h8}};

    rxe_link_model link (.clk(mclk), .rst(rst), .send(snd), .msg(msg),
        .synd(syn), .strobe(lk_strobe), .message(lk_msg),
        .synd_out(lk_syn));
    rxe_unit DUT (.MCLK(mclk), .RST(rst), .NODE_RESET(node_reset),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DONE(cmd_done),
        .WINDOW_OPEN(window_open), .OUT_TAKE(out_take),
        .OUT_LAST(out_last), .MAX_LOAD(max_load),
        .LINK_RX_STROBE(lk_strobe), .LINK_RX_MESSAGE(lk_msg),
        .LINK_RX_SYND(lk_syn), .FRAME_SYNC_ERRORS(fs_err), .IDLE(idle),
        .WINDOW_ACTIVE(win_active), .OUTPUT_READY_PULSE(ready),
        .CHAN_OUT_STROBE(chan_strobe), .IMMEDIATE_LINK_SYNDROME(imm_syn),
        .IMMEDIATE_OVERLOAD_FLAG(imm_ovl), .ALIGNED_MESSAGE_OUT(al_msg),
        .ALIGNED_LINK_SYNDROME(al_syn), .ALIGNED_OVERLOAD_FLAG(al_ovl),
        .INPUT_OVERRUN_FLAG(overrun), .FRAME_SYNC_SYNDROME(fs_out));

    always #5 mclk = ~mclk;

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            close_out();
        end
    end

    // ==========================================
    // bus tasks
    // commands only from idle
    task automatic cmd(input logic [3:0] c, input logic eidle);
        @(posedge mclk);
        cmd_valid <= 1;
        cmd_code <= c;
        @(posedge mclk);
        cmd_valid <= 0;
        #1 `CHK("idle", eidle, idle)
    endtask

    task automatic finish_cmd;
        @(posedge mclk);
        window_open <= 0;
        cmd_done <= 1;
        @(posedge mclk);
        cmd_done <= 0;
        #1 `CHK("idle", 1'b1, idle)
    endtask

    task automatic win;
        @(posedge mclk);
        window_open <= 1;
        @(posedge mclk);
        #1 `CHK("window", 1'b1, win_active)
    endtask

    task automatic send(input int ch, input logic [15:0] m,
        input logic [3:0] s, input logic eo, input logic am,
        input logic [3:0] es);
        @(posedge mclk);
        snd[ch] <= 1;
        msg <= m;
        syn <= s;
        @(posedge mclk);
        snd <= 4'h0;
        @(posedge mclk);
        #1 `CHK("strobe", 4'h1 << ch, chan_strobe)
        `CHK("imm_syn", s, imm_syn[4*ch+:4])
        `CHK("imm_ovl", eo, imm_ovl[ch])
        `CHK("al_syn", es, al_syn[4*ch+:4])
        if (am) begin
            `CHK("al_msg", m, al_msg[16*ch+:16])
        end
    endtask

    task automatic take(input logic last, input logic [15:0] m,
        input logic [3:0] s, input logic eo, input logic er);
        @(posedge mclk);
        out_take <= 1;
        out_last <= last;
        @(posedge mclk);
        out_take <= 0;
        out_last <= 0;
        #1 `CHK("ready", 1'b1, ready)
        `CHK("al_msg", m, al_msg[15:0])
        `CHK("al_syn", s, al_syn[3:0])
        `CHK("al_ovl", eo, al_ovl[0])
        `CHK("overrun", er, overrun[0])
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 0;
        @(posedge mclk);
        #1 `CHK("idle", 1'b1, idle)
        `CHK("strobe", 4'h0, chan_strobe)
        // async monitoring, first strobe outside any window
        cmd(4'h1, 1'b0);
        send(1, 16'h0bad, 4'h6, 1'b0, 1'b1, 4'h0);
        win();
        foreach (rows[k]) begin
            send(rows[k].ch, rows[k].m, rows[k].s, 1'b0, 1'b1,
                rows[k].es);
        end
        finish_cmd();
        $display("async test done");
        // buffered: overload, full drop, read with arrival
        @(posedge mclk);
        max_load <= 3'h2;
        cmd(4'h2, 1'b0);
        win();
        for (int i = 1; i <= 5; i++) begin
            send(0, 16'(16'h100 + i), 4'(i), i > 2, 1'b0, 4'h0);
        end
        @(posedge mclk);
        snd <= 4'h1;
        msg <= 16'h0106;
        syn <= 4'h6;
        @(posedge mclk);
        snd <= 4'h0;
        out_take <= 1;
        @(posedge mclk);
        out_take <= 0;
        #1 `CHK("strobe", 4'h1, chan_strobe)
        `CHK("al_msg", 16'h0101, al_msg[15:0])
        foreach (seq[k]) begin
            take(1'b0, 16'(16'h100 + seq[k]), 4'(seq[k]), seq[k] > 2,
                1'b0);
        end
        send(0, 16'h0107, 4'h7, 1'b0, 1'b0, 4'h0);
        finish_cmd();
        $display("buffered test done");
        // single-message window after leftover entry
        @(posedge mclk);
        max_load <= 3'h1;
        cmd(4'h3, 1'b0);
        win();
        send(0, 16'h0201, 4'h1, 1'b0, 1'b0, 4'h0);
        send(0, 16'h0202, 4'h2, 1'b1, 1'b0, 4'h0);
        take(1'b1, 16'h0201, 4'h1, 1'b0, 1'b1);
        finish_cmd();
        $display("overrun test done");
        // frame sync capture completes on third ready pulse
        @(posedge mclk);
        fs_err <= 4'h9;
        cmd(4'h4, 1'b0);
        win();
        for (int i = 1; i <= 3; i++) begin
            send(0, 16'(16'h300 + i), 4'h0, 1'b0, 1'b0, 4'h0);
            take(1'b0, 16'(16'h300 + i), 4'h0, 1'b0, 1'b0);
            if (i < 3) begin
                `CHK("fsync", 4'h0, fs_out)
            end
        end
        @(posedge mclk);
        #1 `CHK("fsync", 4'h9, fs_out)
        // node reset in mid-window, strobe held off meanwhile
        @(posedge mclk);
        node_reset <= 1;
        snd <= 4'h1;
        @(posedge mclk);
        snd <= 4'h0;
        @(posedge mclk);
        #1 `CHK("idle", 1'b1, idle)
        `CHK("window", 1'b0, win_active)
        `CHK("strobe", 4'h0, chan_strobe)
        @(posedge mclk);
        node_reset <= 0;
        window_open <= 0;
        $display("reset test done");
        // remaining command codes
        cmd(4'h0, 1'b1);
        for (int c = 5; c <= 8; c++) begin
            cmd(4'(c), 1'b0);
            finish_cmd();
        end
        $display("command test done");
        close_out();
    end
endmodule
